//--- verilog/cto_comm_supervisor.sv
// Purpose: frame timeouts, debug port control, multidrop and broadcast order
// Assumes: APB slave, 40 MHz clock, frame events from the frame engine
// Notes:   one wait state on every APB access
//
// Register access over APB and the register addresses were left to the implementer.
module cto_comm_supervisor #(
   parameter int unsigned TICK_CYCLES = cto_pkg::TICK_CYCLES
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [cto_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]               i_pwdata,
   output logic      [31:0]               o_prdata,
   output logic                           o_pready,
   output logic                           o_pslverr,
   input  wire logic [2:0]                i_pwr_mode,
   input  wire logic                      i_frame_done,
   input  wire logic                      i_frame_err,
   input  wire logic [3:0]                i_hw_chain_en,
   input  wire logic [15:0]               i_link_fault,
   input  wire logic                      i_bcast_rd,
   input  wire logic                      i_upper_resp_done,
   output logic                           o_upper_tx_en,
   output logic                           o_upper_rx_en,
   output logic                           o_lower_tx_en,
   output logic                           o_lower_rx_en,
   output logic                           o_serial_tx_en,
   output logic                           o_mirror_en,
   output logic                           o_baud_slow,
   output logic                           o_baud_tick,
   output logic                           o_sleep_req,
   output logic                           o_shutdown_req,
   output logic                           o_resp_go
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
      logic [8:0]            to_cfg;
      logic [1:0]            fault;
      logic [7:0]            unlock;
      logic [4:0]            dbg_a;
      logic [3:0]            dbg_b;
      logic [2:0]            comm;
      logic [15:0]           link_flt;
      logic [cto_pkg::TICK_W-1:0] tick_cnt;
      logic                  tick;
      logic [7:0]            baud_cnt;
      logic                  baud_tick;
      logic [3:0]            chain_en;
      logic                  ser_tx;
      logic                  mirror;
      logic                  baud_slow;
      logic                  sleep_req;
      logic                  shut_req;
      cto_pkg::cto_bc_t      bc;
      logic                  resp_go;
   } cto_main_st_t;

   cto_main_st_t st_r;
   cto_main_st_t st_nxt;

   logic        debug_on;
   logic        ser_user;
   logic        daisy_user;
   logic        mdrop;
   logic        frame_ok;
   logic        pwr_active;
   logic        pwr_shut;
   logic        acc_done;
   logic        wr_en;
   logic        hit;
   logic [31:0] rd_data;
   logic [1:0]  flt_clr;
   logic        s_set;
   logic        l_set;
   logic        l_shut;
   logic [7:0]  baud_lim;
   logic [7:0]  dbg_stat;

   ////////////////////////////////////////////////////////////////////////////
   // mode decode

   assign debug_on   = st_r.unlock == cto_pkg::UNLOCK_CODE;
   assign ser_user   = debug_on & st_r.dbg_a[cto_pkg::DBA_SERIAL];
   assign daisy_user = debug_on & st_r.dbg_a[cto_pkg::DBA_DAISY];
   assign mdrop      = st_r.comm[cto_pkg::COMM_MDROP];
   assign frame_ok   = i_frame_done & ~i_frame_err;
   assign pwr_active = i_pwr_mode == cto_pkg::PWR_ACTIVE;
   assign pwr_shut   = i_pwr_mode == cto_pkg::PWR_SHUTDOWN;

   ////////////////////////////////////////////////////////////////////////////
   // timers

   cto_tmr_if s_if ();
   cto_tmr_if l_if ();

   assign s_if.tick    = st_r.tick;
   assign s_if.run     = st_r.to_cfg[cto_pkg::CFG_SHORT_EN] & pwr_active;
   assign s_if.clr     = ~st_r.to_cfg[cto_pkg::CFG_SHORT_EN] | pwr_shut;
   assign s_if.restart = frame_ok;
   assign s_if.limit   = cto_pkg::SHORT_MS[st_r.to_cfg[2:0]];

   assign l_if.tick    = st_r.tick;
   assign l_if.run     = st_r.to_cfg[cto_pkg::CFG_LONG_EN] & pwr_active;
   assign l_if.clr     = ~st_r.to_cfg[cto_pkg::CFG_LONG_EN] | pwr_shut;
   assign l_if.restart = frame_ok;
   assign l_if.limit   = cto_pkg::LONG_MS[st_r.to_cfg[6:4]];

   cto_timer u_short (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .tmr     (s_if.tmr)
   );

   cto_timer u_long (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .tmr     (l_if.tmr)
   );

   assign s_set  = s_if.expired & st_r.to_cfg[cto_pkg::CFG_SHORT_EN];
   assign l_set  = l_if.expired & st_r.to_cfg[cto_pkg::CFG_LONG_EN]
                   & ~st_r.to_cfg[cto_pkg::CFG_LONG_ACT];
   assign l_shut = l_if.expired & st_r.to_cfg[cto_pkg::CFG_LONG_EN]
                   & st_r.to_cfg[cto_pkg::CFG_LONG_ACT];

   ////////////////////////////////////////////////////////////////////////////
   // apb decode and read mux

   assign acc_done = i_psel & i_penable & st_r.pready;
   assign wr_en    = acc_done & i_pwrite & hit;
   assign flt_clr  = (wr_en && i_paddr == cto_pkg::OFS_FAULT) ? i_pwdata[1:0] : 2'b00;
   assign dbg_stat = {1'b0, debug_on, st_r.chain_en, daisy_user, ser_user};

   always_comb begin
      hit     = 1'b1;
      rd_data = '0;
      case (i_paddr)
         cto_pkg::OFS_TO_CFG:  rd_data[8:0]  = st_r.to_cfg;
         cto_pkg::OFS_FAULT:   rd_data[1:0]  = st_r.fault;
         cto_pkg::OFS_UNLOCK:  rd_data[7:0]  = st_r.unlock;
         cto_pkg::OFS_DBG_A:   rd_data[4:0]  = st_r.dbg_a;
         cto_pkg::OFS_DBG_B:   rd_data[3:0]  = st_r.dbg_b;
         cto_pkg::OFS_DBG_ST:  rd_data[7:0]  = dbg_stat;
         cto_pkg::OFS_COMM:    rd_data[2:0]  = st_r.comm;
         cto_pkg::OFS_LNK_FLT: rd_data[15:0] = st_r.link_flt;
         default:              hit           = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_nxt         = st_r;
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (i_psel && i_penable && !st_r.pready) begin
         st_nxt.pready  = 1'b1;
         st_nxt.pslverr = ~hit;
         st_nxt.prdata  = rd_data;
      end
      if (wr_en) begin
         case (i_paddr)
            cto_pkg::OFS_TO_CFG: st_nxt.to_cfg = i_pwdata[8:0];
            cto_pkg::OFS_UNLOCK: st_nxt.unlock = i_pwdata[7:0];
            cto_pkg::OFS_DBG_A:  st_nxt.dbg_a  = i_pwdata[4:0];
            cto_pkg::OFS_DBG_B:  st_nxt.dbg_b  = i_pwdata[3:0];
            cto_pkg::OFS_COMM:   st_nxt.comm   = i_pwdata[2:0];
            default:             st_nxt.comm   = st_r.comm;
         endcase
      end
      // sticky fault flags, a new event beats a clear; link faults follow the input, requests pulse
      st_nxt.fault = (st_r.fault & ~flt_clr) | {l_set, s_set};
      st_nxt.link_flt = i_link_fault;
      st_nxt.sleep_req = l_set;
      st_nxt.shut_req  = l_shut;

      // 1 ms tick
      if (st_r.tick_cnt == 16'(TICK_CYCLES - 1)) begin
         st_nxt.tick_cnt = '0;
         st_nxt.tick     = 1'b1;
      end else begin
         st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
         st_nxt.tick     = 1'b0;
      end

      // serial bit-rate enable
      if (st_r.baud_cnt >= baud_lim) begin
         st_nxt.baud_cnt  = '0;
         st_nxt.baud_tick = 1'b1;
      end else begin
         st_nxt.baud_cnt  = st_r.baud_cnt + 1'b1;
         st_nxt.baud_tick = 1'b0;
      end
      st_nxt.baud_slow = ser_user & st_r.dbg_a[cto_pkg::DBA_BAUD];

      // chain port enables
      if (mdrop) begin
         st_nxt.chain_en = 4'h0;
      end else if (daisy_user) begin
         st_nxt.chain_en = st_r.dbg_b;
      end else begin
         st_nxt.chain_en = i_hw_chain_en;
      end

      // serial port
      if (ser_user) begin
         st_nxt.ser_tx = st_r.dbg_a[cto_pkg::DBA_TX_EN];
         st_nxt.mirror = st_r.dbg_a[cto_pkg::DBA_MIRROR];
      end else begin
         st_nxt.ser_tx = ~st_r.comm[cto_pkg::COMM_STACK];
         st_nxt.mirror = 1'b0;
      end

      // broadcast read turn, same in chain and multidrop
      case (st_r.bc)
         cto_pkg::BC_IDLE: begin
            if (i_bcast_rd) begin
               if (st_r.comm[cto_pkg::COMM_TOS]) begin
                  st_nxt.bc = cto_pkg::BC_SEND;
               end else begin
                  st_nxt.bc = cto_pkg::BC_WAIT;
               end
            end
         end
         cto_pkg::BC_WAIT: begin
            if (i_upper_resp_done) begin
               st_nxt.bc = cto_pkg::BC_SEND;
            end
         end
         cto_pkg::BC_SEND: begin
            st_nxt.bc = cto_pkg::BC_IDLE;
         end
         default: begin
            st_nxt.bc = cto_pkg::BC_IDLE;
         end
      endcase
      st_nxt.resp_go = st_nxt.bc == cto_pkg::BC_SEND;
   end

   assign baud_lim = st_r.baud_slow ? cto_pkg::BIT_SLOW_CYC - 8'h01
                                    : cto_pkg::BIT_FAST_CYC - 8'h01;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r        <= '0;
         st_r.to_cfg <= cto_pkg::RST_TO_CFG;
         st_r.unlock <= cto_pkg::RST_UNLOCK;
         st_r.dbg_a  <= cto_pkg::RST_DBG_A;
         st_r.dbg_b  <= cto_pkg::RST_DBG_B;
         st_r.comm   <= cto_pkg::RST_COMM;
         st_r.bc     <= cto_pkg::BC_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_prdata       = st_r.prdata;
   assign o_pready       = st_r.pready;
   assign o_pslverr      = st_r.pslverr;
   assign o_upper_tx_en  = st_r.chain_en[0];
   assign o_upper_rx_en  = st_r.chain_en[1];
   assign o_lower_tx_en  = st_r.chain_en[2];
   assign o_lower_rx_en  = st_r.chain_en[3];
   assign o_serial_tx_en = st_r.ser_tx;
   assign o_mirror_en    = st_r.mirror;
   assign o_baud_slow    = st_r.baud_slow;
   assign o_baud_tick    = st_r.baud_tick;
   assign o_sleep_req    = st_r.sleep_req;
   assign o_shutdown_req = st_r.shut_req;
   assign o_resp_go      = st_r.resp_go;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   property p_short_flag;
      s_if.expired |=> st_r.fault[cto_pkg::FLT_SHORT];
   endproperty
   a_short_flag: assert property (p_short_flag)
      else $error("short expiry did not set its flag");

   sequence s_long_exp_sleep;
      l_if.expired && !st_r.to_cfg[cto_pkg::CFG_LONG_ACT];
   endsequence
   property p_long_sleep;
      s_long_exp_sleep |=> o_sleep_req && st_r.fault[cto_pkg::FLT_LONG]
                           ##1 !o_sleep_req;
   endproperty
   a_long_sleep: assert property (p_long_sleep)
      else $error("long expiry did not flag and request sleep");

   property p_long_shut;
      l_if.expired && st_r.to_cfg[cto_pkg::CFG_LONG_ACT]
         |=> o_shutdown_req && !o_sleep_req;
   endproperty
   a_long_shut: assert property (p_long_shut)
      else $error("long expiry did not request shutdown");

   property p_no_flag_disabled;
      !st_r.to_cfg[cto_pkg::CFG_SHORT_EN] && !st_r.fault[cto_pkg::FLT_SHORT]
         |=> !st_r.fault[cto_pkg::FLT_SHORT];
   endproperty
   a_no_flag_disabled: assert property (p_no_flag_disabled)
      else $error("disabled short timeout raised its flag");

   property p_mdrop_off;
      mdrop |=> st_r.chain_en == 4'h0;
   endproperty
   a_mdrop_off: assert property (p_mdrop_off)
      else $error("chain port enabled under multidrop");

   property p_locked_hw;
      !debug_on && !mdrop |=> st_r.chain_en == $past(i_hw_chain_en) && !o_mirror_en;
   endproperty
   a_locked_hw: assert property (p_locked_hw)
      else $error("chain or serial not under hardware control when locked");

   property p_daisy_user;
      daisy_user && !mdrop |=> st_r.chain_en == $past(st_r.dbg_b);
   endproperty
   a_daisy_user: assert property (p_daisy_user)
      else $error("chain enables do not follow user control");

   property p_mirror;
      ser_user && st_r.dbg_a[cto_pkg::DBA_MIRROR] |=> o_mirror_en;
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("mirror not enabled");

   property p_ser_hw;
      !ser_user |=> !o_mirror_en && !o_baud_slow
                    && o_serial_tx_en == !$past(st_r.comm[cto_pkg::COMM_STACK]);
   endproperty
   a_ser_hw: assert property (p_ser_hw)
      else $error("serial debug bits acted without user serial control");

   property p_baud;
      o_baud_tick && $stable(o_baud_slow) && !o_baud_slow
         |=> !o_baud_tick [*8];
   endproperty
   a_baud: assert property (p_baud)
      else $error("fast bit period too short");

   sequence s_bc_tos;
      i_bcast_rd && st_r.comm[cto_pkg::COMM_TOS] && st_r.bc == cto_pkg::BC_IDLE;
   endsequence
   property p_bc_tos;
      s_bc_tos |=> o_resp_go ##1 !o_resp_go;
   endproperty
   a_bc_tos: assert property (p_bc_tos)
      else $error("top device did not answer broadcast read first");

   property p_bc_wait;
      st_r.bc == cto_pkg::BC_WAIT && !i_upper_resp_done |=> !o_resp_go;
   endproperty
   a_bc_wait: assert property (p_bc_wait)
      else $error("lower device answered before its upper neighbour");

   property p_apb_wait;
      i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("apb answer not one cycle after access start");

endmodule : cto_comm_supervisor

//--- verilog/cto_pkg.sv
// Purpose: shared constants and types of the frame-timeout supervisor
// Assumes: 40 MHz clock, APB register access, 32-bit data
// Notes:   timeout periods are in units of the 1 ms tick; clock, tick and bit periods are in ns
package cto_pkg;

   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYCLES    =
      (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BIT_FAST_NS    = 1000;
   localparam int unsigned BIT_SLOW_NS    = 4000;
   localparam logic [7:0]  BIT_FAST_CYC   = 8'(BIT_FAST_NS / CLK_PERIOD_NS);
   localparam logic [7:0]  BIT_SLOW_CYC   = 8'(BIT_SLOW_NS / CLK_PERIOD_NS);

   localparam int          CNT_W  = 20;
   localparam int          TICK_W = 16;
   localparam int          ADDR_W = 8;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_TO_CFG  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FAULT   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_UNLOCK  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DBG_A   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_DBG_B   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_DBG_ST  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_COMM    = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_LNK_FLT = 8'h1c;

   // fields
   localparam int CFG_SHORT_LSB = 0;
   localparam int CFG_SHORT_EN  = 3;
   localparam int CFG_LONG_LSB  = 4;
   localparam int CFG_LONG_EN   = 7;
   localparam int CFG_LONG_ACT  = 8;
   localparam int FLT_SHORT     = 0;
   localparam int FLT_LONG      = 1;
   localparam int DBA_DAISY     = 0;
   localparam int DBA_SERIAL    = 1;
   localparam int DBA_MIRROR    = 2;
   localparam int DBA_TX_EN     = 3;
   localparam int DBA_BAUD      = 4;
   localparam int COMM_MDROP    = 0;
   localparam int COMM_STACK    = 1;
   localparam int COMM_TOS      = 2;
   localparam int ST_SER_USER   = 0;
   localparam int ST_DAISY_USER = 1;
   localparam int ST_CHAIN_LSB  = 2;
   localparam int ST_DEBUG      = 6;

   // reset values
   localparam logic [8:0] RST_TO_CFG = 9'h000;
   localparam logic [7:0] RST_UNLOCK = 8'h00;
   localparam logic [4:0] RST_DBG_A  = 5'h00;
   localparam logic [3:0] RST_DBG_B  = 4'h0;
   localparam logic [2:0] RST_COMM   = 3'h0;
   localparam logic [7:0] UNLOCK_CODE = 8'ha5;

   // timeout periods in ms, indexed by the 3-bit period field
   localparam logic [CNT_W-1:0] SHORT_MS [8] = '{
      20'h00064, 20'h000c8, 20'h001f4, 20'h003e8,
      20'h007d0, 20'h01388, 20'h02710, 20'h04e20};
   localparam logic [CNT_W-1:0] LONG_MS [8] = '{
      20'h003e8, 20'h007d0, 20'h01388, 20'h02710,
      20'h0ea60, 20'h1d4c0, 20'h493e0, 20'h927c0};

   typedef enum logic [2:0] {
      PWR_ACTIVE   = 3'b001,
      PWR_SLEEP    = 3'b010,
      PWR_SHUTDOWN = 3'b100
   } cto_pwr_t;

   typedef enum logic [2:0] {
      BC_IDLE = 3'b001,
      BC_WAIT = 3'b010,
      BC_SEND = 3'b100
   } cto_bc_t;

endpackage : cto_pkg

//--- verilog/cto_tmr_if.sv
// Purpose: control and result of one no-frame timer
// Assumes: all signals on the block clock
// Notes:   ctl drives, tmr counts
interface cto_tmr_if;
   logic                    tick;
   logic                    run;
   logic                    clr;
   logic                    restart;
   logic [cto_pkg::CNT_W-1:0] limit;
   logic                    expired;
   modport ctl (output tick, run, clr, restart, limit, input expired);
   modport tmr (input tick, run, clr, restart, limit, output expired);
endinterface : cto_tmr_if

//--- verilog/cto_timer.sv
// Purpose: one no-frame timer counting ms ticks
// Assumes: tick is a one-cycle enable
// Notes:   expired is a one-cycle pulse
module cto_timer (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   cto_tmr_if.tmr    tmr
);

   typedef struct packed {
      logic [cto_pkg::CNT_W-1:0] cnt;
      logic                      expired;
   } cto_tmr_st_t;

   cto_tmr_st_t               st_r;
   cto_tmr_st_t               st_nxt;
   logic [cto_pkg::CNT_W-1:0] cnt_inc;

   assign cnt_inc = st_r.cnt + 1'b1;

   always_comb begin
      st_nxt         = st_r;
      st_nxt.expired = 1'b0;
      if (tmr.clr) begin
         st_nxt.cnt = '0;
      end else if (tmr.restart) begin
         st_nxt.cnt = '0;
      end else if (tmr.run && tmr.tick) begin
         if (cnt_inc >= tmr.limit) begin
            st_nxt.cnt     = '0;
            st_nxt.expired = 1'b1;
         end else begin
            st_nxt.cnt = cnt_inc;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tmr.expired = st_r.expired;

endmodule : cto_timer

//--- testbench/cto_host_model.sv
// Purpose: host side that hands finished frames to the supervisor
// Assumes: one frame per request, same clock as the block
// Notes:   error level scrambles between frames
module cto_host_model (
   input  wire logic i_clk,
   input  wire logic i_send,
   input  wire logic i_bad,
   output logic      o_frame_done,
   output logic      o_frame_err
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_frame_done = 1'b0;
      o_frame_err  = 1'b1;
   end
   // error flag only has meaning alongside done
   // each request stands for one frame sent after a frame clear
   always @(posedge i_clk) begin
      o_frame_done <= i_send;
      o_frame_err  <= i_send ? i_bad : ~o_frame_err;
   end
endmodule : cto_host_model

//--- testbench/cto_comm_supervisor_test.sv
// Purpose: self-checking bench of the frame-timeout supervisor
// Assumes: TICK_CYCLES of 4, so one ms tick is 4 clocks
// Notes:   bench plays APB master and power logic
module cto_comm_supervisor_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, er, go = 0, bad = 0, fd, fe, bc = 0;
   logic [7:0]  pa = 0;
   logic [31:0] pw = 0, prd, rd;
   logic [2:0]  mode = 3'h1;
   logic [3:0]  hw = 4'ha;
   logic        pready, perr, ute, ure, lte, lre, ste, mir, slow, slp, sd, rgo, bt;
   logic        ur = 0;
   logic [15:0] lf = 16'h5a3c;
   int          fail_count = 0, total_checks = 0, sd_n = 0, sl_n = 0, go_n = 0, bt_n = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      sd_n <= sd_n + sd;
      sl_n <= sl_n + slp;
      go_n <= go_n + rgo;
      bt_n <= bt_n + bt;
   end
   cto_host_model cto_host_model_inst (.i_clk(clk), .i_send(go), .i_bad(bad),
      .o_frame_done(fd), .o_frame_err(fe));
   cto_comm_supervisor #(.TICK_CYCLES(4)) cto_comm_supervisor_inst (.i_clk(clk),
      .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
      .i_pwdata(pw), .o_prdata(prd), .o_pready(pready), .o_pslverr(perr),
      .i_pwr_mode(mode), .i_frame_done(fd), .i_frame_err(fe), .i_hw_chain_en(hw),
      .i_link_fault(lf), .i_bcast_rd(bc), .i_upper_resp_done(ur),
      .o_upper_tx_en(ute), .o_upper_rx_en(ure), .o_lower_tx_en(lte), .o_lower_rx_en(lre),
      .o_serial_tx_en(ste), .o_mirror_en(mir), .o_baud_slow(slow), .o_baud_tick(bt),
      .o_sleep_req(slp), .o_shutdown_req(sd), .o_resp_go(rgo));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr  <= w;
      pa   <= a;
      pw   <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (n >= 50) chk(0, 1);
   endtask : apb
   task automatic frame(input logic b);
      @(posedge clk);
      go  <= 1'b1;
      bad <= b;
      @(posedge clk);
      go <= 1'b0;
   endtask : frame
   task automatic final_report();
      if (fail_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_debug();
      int b;
      apb(0, 8'h20, 0);
      chk(er, 1);
      apb(0, cto_pkg::OFS_TO_CFG, 0);
      chk(rd, 0);
      chk(ste, 1);
      apb(1, cto_pkg::OFS_DBG_A, 32'h1f);
      apb(1, cto_pkg::OFS_DBG_B, 32'h5);
      chk({lre, lte, ure, ute, mir}, {hw, 1'b0});
      apb(1, cto_pkg::OFS_UNLOCK, 32'ha5);
      repeat (2) @(posedge clk);
      chk({lre, lte, ure, ute}, 4'h5);
      chk({mir, slow, ste}, 3'h7);
      b = bt_n;
      repeat (320) @(posedge clk);
      chk(bt_n - b, 2);
      apb(0, cto_pkg::OFS_DBG_ST, 0);
      chk(rd, 32'h57);
      apb(1, cto_pkg::OFS_DBG_A, 32'h1c);
      repeat (2) @(posedge clk);
      chk({lre, lte, ure, ute, mir, slow, ste}, {hw, 3'h1});
      b = bt_n;
      repeat (400) @(posedge clk);
      chk(bt_n - b, 10);
      apb(1, cto_pkg::OFS_DBG_A, 32'h1f);
      apb(1, cto_pkg::OFS_UNLOCK, 0);
      repeat (2) @(posedge clk);
      chk({lre, lte, ure, ute, mir, slow, ste}, {hw, 3'h1});
      apb(1, cto_pkg::OFS_COMM, 1);
      repeat (2) @(posedge clk);
      chk({lre, lte, ure, ute}, 0);
      apb(1, cto_pkg::OFS_COMM, 4);
      bc <= 1'b1;
      @(posedge clk);
      bc <= 1'b0;
      repeat (5) @(posedge clk);
      chk(go_n, 1);
      apb(0, cto_pkg::OFS_LNK_FLT, 0);
      chk(rd, 32'h5a3c);
      apb(1, cto_pkg::OFS_COMM, 0);
      bc <= 1'b1;
      @(posedge clk);
      bc <= 1'b0;
      repeat (5) @(posedge clk);
      chk(go_n, 1);
      ur <= 1'b1;
      @(posedge clk);
      ur <= 1'b0;
      repeat (5) @(posedge clk);
      chk(go_n, 2);
   endtask : t_debug
   task automatic t_short();
      apb(1, cto_pkg::OFS_TO_CFG, 32'h8);
      repeat (4) begin
         repeat (300) @(posedge clk);
         frame(0);
      end
      apb(0, cto_pkg::OFS_FAULT, 0);
      chk(rd, 0);
      repeat (150) @(posedge clk);
      frame(1);
      repeat (300) @(posedge clk);
      apb(0, cto_pkg::OFS_FAULT, 0);
      chk(rd, 1);
      mode <= 3'h2;
      apb(1, cto_pkg::OFS_FAULT, 1);
      repeat (900) @(posedge clk);
      apb(0, cto_pkg::OFS_FAULT, 0);
      chk(rd, 0);
      mode <= 3'h1;
      apb(1, cto_pkg::OFS_TO_CFG, 0);
      repeat (900) @(posedge clk);
      apb(0, cto_pkg::OFS_FAULT, 0);
      chk(rd, 0);
   endtask : t_short
   task automatic t_long();
      apb(1, cto_pkg::OFS_TO_CFG, 32'h180);
      frame(0);
      repeat (3900) @(posedge clk);
      chk(sd_n, 0);
      repeat (200) @(posedge clk);
      chk({sd_n, sl_n}, {32'd1, 32'd0});
      mode <= 3'h4;
      repeat (10) @(posedge clk);
      mode <= 3'h1;
      apb(1, cto_pkg::OFS_TO_CFG, 32'h80);
      repeat (4100) @(posedge clk);
      chk(sl_n, 1);
      apb(0, cto_pkg::OFS_FAULT, 0);
      chk(rd, 2);
   endtask : t_long
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_debug();
      t_short();
      t_long();
      final_report();
   end
   initial begin
      #750000;
      fail_count++;
      final_report();
   end
endmodule : cto_comm_supervisor_test
